// *** src/onewire_supervisor.sv ***
/*
  Register-level 1-wire sensor manager with communication watchdogs.
  Assumes a Modbus front end on the same clock that gives word accesses and
  a valid-frame pulse, and a 1-wire engine that performs search and reads.
*/
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module onewire_supervisor #(
  parameter int SEC_CYCLES = `SEC_NS / `CLK_NS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_rvalid,
  input  wire logic        i_frame_valid,
  input  wire logic        i_query_active,
  input  wire logic        i_supply_ok,
  output logic             o_ow_search,
  output logic             o_ow_read,
  output logic      [63:0] o_ow_rom,
  output logic             o_ow_take,
  output logic      [15:0] o_ow_delay,
  input  wire logic        i_ow_found,
  input  wire logic [63:0] i_ow_found_id,
  input  wire logic        i_ow_done,
  input  wire logic        i_ow_ok,
  input  wire logic [11:0] i_ow_temp,
  output logic             o_supply_en,
  output logic             o_module_reset
);
  sup_pkg::sup_s r, n;

  // ============================================================
  // Address decode
  logic [15:0] o_t1, o_t2, o_i1, o_i2;
  logic        t1, t2, i1, i2, m_acc, t_hit, id_hit, tick, lock;
  logic [4:0]  m_tslot, m_islot;
  logic [1:0]  m_lane;
  logic [63:0] id_rdata, f_iwd;
  logic [15:0] t_rdata, f_twd, rmux;
  logic [4:0]  f_ia, f_ta, id_a, t_a;
  logic [3:0]  f_iwe, id_we;
  logic        f_twe, t_we;

  assign o_t1    = i_reg_addr - `A_T1;
  assign o_t2    = i_reg_addr - `A_T2;
  assign o_i1    = i_reg_addr - `A_ID1;
  assign o_i2    = i_reg_addr - `A_ID2;
  assign t1      = o_t1 < `GRP_T;
  assign t2      = o_t2 < `GRP_T;
  assign i1      = o_i1 < `GRP_W;
  assign i2      = o_i2 < `GRP_W;
  assign m_acc   = i_reg_wr | i_reg_rd;
  assign t_hit   = m_acc & (t1 | t2);
  assign id_hit  = m_acc & (i1 | i2);
  // Group two starts at slot nine; word zero holds the top of the code.
  assign m_tslot = t1 ? o_t1[4:0] : 5'(o_t2[4:0] + `GRP);
  assign m_islot = i1 ? o_i1[6:2] : 5'(o_i2[6:2] + `GRP);
  assign m_lane  = 2'h3 - (i1 ? o_i1[1:0] : o_i2[1:0]);
  assign tick    = r.sec == 32'(SEC_CYCLES - 1);
  assign lock    = r.lockdly[`LOCK_BIT];

  // Register bus accesses take the memory ports; the sequencer retries.
  assign id_a  = id_hit ? m_islot : f_ia;
  assign id_we = id_hit ? (i_reg_wr ? 4'h1 << m_lane : 4'h0) : f_iwe;
  assign t_a   = t_hit ? m_tslot : f_ta;
  assign t_we  = t_hit ? 1'b0 : f_twe;

  sensor_mem #(.LANES(4), .LANE_W(16), .DEPTH(`NSLOT), .AW(5)) u_id (
    .i_ref_clk (i_ref_clk),
    .i_addr    (id_a),
    .i_we      (id_we),
    .i_wdata   (id_hit ? {4{i_reg_wdata}} : f_iwd),
    .o_rdata   (id_rdata)
  );
  sensor_mem #(.LANES(1), .LANE_W(16), .DEPTH(`NSLOT), .AW(5)) u_tmp (
    .i_ref_clk (i_ref_clk),
    .i_addr    (t_a),
    .i_we      (t_we),
    .i_wdata   (f_twd),
    .o_rdata   (t_rdata)
  );

  always_comb begin
    unique case (i_reg_addr)
      `A_STATUS:  rmux = {r.flip, 14'h0, r.s2};
      `A_CUT_TO:  rmux = r.cut_to;
      `A_CUT_LEN: rmux = r.cut_len;
      `A_RST_TO:  rmux = r.rst_to;
      `A_IVAL:    rmux = r.ival;
      `A_LOCK:    rmux = r.lockdly;
      default:    rmux = 16'h0;
    endcase
  end

  // ============================================================
  // Next state
  always_comb begin
    n     = r;
    f_ia  = 5'h0;
    f_iwe = 4'h0;
    f_iwd = 64'h0;
    f_ta  = 5'h0;
    f_twe = 1'b0;
    f_twd = 16'h0;
    n.mrst = 1'b0;
    n.srch = 1'b0;
    n.rd   = 1'b0;
    n.take = 1'b0;
    n.s1   = i_supply_ok;
    n.s2   = r.s1;
    n.sec  = tick ? 32'h0 : r.sec + 32'h1;
    if (tick && r.ival_left != 16'h0) begin
      n.ival_left = r.ival_left - 16'h1;
    end

    // Read path: two clocks, so the answer always leaves a flip-flop.
    n.p_vld  = i_reg_rd;
    n.p_lane = m_lane;
    n.p_data = rmux;
    n.p_src  = id_hit ? sup_pkg::SRC_ID :
               t_hit ? sup_pkg::SRC_TMP : sup_pkg::SRC_REG;
    n.rvalid = r.p_vld;
    unique case (r.p_src)
      sup_pkg::SRC_ID:  n.rdata = id_rdata[r.p_lane*16 +: 16];
      sup_pkg::SRC_TMP: n.rdata = t_rdata;
      default:          n.rdata = r.p_data;
    endcase

    // Supply-cut watchdog.
    if (r.cut_to == 16'h0 || r.cut_len == 16'h0) begin
      n.cut_idle = 16'h0;
    end else if (r.cut_left != 16'h0) begin
      n.cut_idle = 16'h0;
    end else if (tick) begin
      if (16'(r.cut_idle + 16'h1) >= r.cut_to) begin
        n.cut_left = r.cut_len;
        n.cut_idle = 16'h0;
      end else begin
        n.cut_idle = r.cut_idle + 16'h1;
      end
    end
    if (tick && r.cut_left != 16'h0) begin
      n.cut_left = r.cut_left - 16'h1;
    end

    // Module-reset watchdog.
    if (r.rst_to == 16'h0) begin
      n.rst_idle = 16'h0;
    end else if (tick) begin
      if (16'(r.rst_idle + 16'h1) >= r.rst_to) begin
        n.mrst      = 1'b1;
        n.rst_idle  = 16'h0;
        n.disc      = !lock;
        n.slot      = 5'h0;
        n.ival_left = 16'h0;
      end else begin
        n.rst_idle = r.rst_idle + 16'h1;
      end
    end
    if (i_frame_valid) begin
      n.cut_idle = 16'h0;
      n.rst_idle = 16'h0;
      n.gap      = 1'b1;
    end

    if (i_reg_wr) begin
      case (i_reg_addr)
        `A_CUT_TO:  n.cut_to  = i_reg_wdata;
        `A_CUT_LEN: n.cut_len = i_reg_wdata;
        `A_RST_TO:  n.rst_to  = i_reg_wdata;
        `A_IVAL:    n.ival    = i_reg_wdata;
        `A_LOCK:    n.lockdly = i_reg_wdata;
        `A_CMD: begin
          if (i_reg_wdata == `CMD_DISC && !lock) begin
            n.disc = 1'b1;
          end
          if (i_reg_wdata == `CMD_CUT && r.cut_len != 16'h0) begin
            n.cut_left = r.cut_len;
            n.cut_idle = 16'h0;
          end
        end
        default: ;
      endcase
    end

    // Sensor sequencer.
    unique case (r.st)
      sup_pkg::ST_CLR: begin
        f_ia  = r.idx;
        f_iwe = 4'hf;
        f_ta  = r.idx;
        f_twe = 1'b1;
        f_twd = `T_FAIL;
        if (!id_hit && !t_hit) begin
          n.idx = 5'(r.idx + 5'h1);
          if (r.idx == `LAST_SLOT) begin
            n.idx = 5'h0;
            n.st  = sup_pkg::ST_IDLE;
            if (r.csr && r.ival != 16'h0 && !lock) begin
              n.srch = 1'b1;
              n.disc = 1'b0;
              n.cnt  = 5'h0;
              n.st   = sup_pkg::ST_SRCH;
            end
            n.csr = 1'b0;
          end
        end
      end
      sup_pkg::ST_IDLE: begin
        if (r.ival != 16'h0) begin
          if (r.disc) begin
            n.disc = !lock;
            n.csr  = 1'b1;
            n.st   = lock ? sup_pkg::ST_IDLE : sup_pkg::ST_CLR;
          end else if (!i_query_active &&
                       (r.gap || r.ival_left == 16'h0)) begin
            n.gap = 1'b0;
            n.st  = sup_pkg::ST_RD_ID;
          end
        end
      end
      sup_pkg::ST_SRCH: begin
        if (i_ow_found && !r.take) begin
          n.nid = i_ow_found_id;
          n.idx = r.cnt;
          if (r.cnt == 5'(`NSLOT)) begin
            n.take = 1'b1;
          end else begin
            n.st = sup_pkg::ST_INS_RD;
          end
        end else if (i_ow_done) begin
          n.slot      = 5'h0;
          n.ival_left = 16'h0;
          n.st        = sup_pkg::ST_IDLE;
        end
      end
      sup_pkg::ST_INS_RD: begin
        if (!id_hit) begin
          if (r.idx == 5'h0) begin
            f_ia  = 5'h0;
            f_iwe = 4'hf;
            f_iwd = r.nid;
            n.cnt  = 5'(r.cnt + 5'h1);
            n.take = 1'b1;
            n.st   = sup_pkg::ST_SRCH;
          end else begin
            f_ia = 5'(r.idx - 5'h1);
            n.st = sup_pkg::ST_INS_CMP;
          end
        end
      end
      sup_pkg::ST_INS_CMP: begin
        f_ia  = r.idx;
        f_iwe = 4'hf;
        if (id_hit) begin
          f_iwe = 4'h0;
          n.st  = sup_pkg::ST_INS_RD;
        end else if (id_rdata > r.nid) begin
          f_iwd = id_rdata;
          n.idx = 5'(r.idx - 5'h1);
          n.st  = sup_pkg::ST_INS_RD;
        end else begin
          f_iwd  = r.nid;
          n.cnt  = 5'(r.cnt + 5'h1);
          n.take = 1'b1;
          n.st   = sup_pkg::ST_SRCH;
        end
      end
      sup_pkg::ST_RD_ID: begin
        f_ia = r.slot;
        if (!id_hit) begin
          n.st = sup_pkg::ST_RD_WAIT;
        end
      end
      sup_pkg::ST_RD_WAIT: begin
        if (id_rdata == 64'h0) begin
          n.tval = `T_FAIL;
          n.okf  = 1'b0;
          n.st   = sup_pkg::ST_RD_WR;
        end else begin
          n.rom = id_rdata;
          n.rd  = 1'b1;
          n.st  = sup_pkg::ST_RD_BUS;
        end
      end
      sup_pkg::ST_RD_BUS: begin
        if (i_ow_done) begin
          n.okf  = i_ow_ok;
          n.tval = i_ow_ok ? {{4{i_ow_temp[11]}}, i_ow_temp}
                           : `T_FAIL;
          n.st   = sup_pkg::ST_RD_WR;
        end
      end
      sup_pkg::ST_RD_WR: begin
        f_ta  = r.slot;
        f_twe = 1'b1;
        f_twd = r.tval;
        if (!t_hit) begin
          n.ival_left = r.ival;
          n.slot      = 5'(r.slot + 5'h1);
          n.st        = sup_pkg::ST_IDLE;
          if (r.slot == `LAST_SLOT) begin
            n.slot = 5'h0;
            n.flip = !r.flip;
          end
        end
      end
    endcase
    n.sup_en = n.cut_left == 16'h0;
  end

  // Only the power-on reset clears 699; the watchdog reset keeps it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r        <= '0;
      r.st     <= sup_pkg::ST_CLR;
      r.p_src  <= sup_pkg::SRC_REG;
      r.ival   <= `IVAL_RST;
      r.sup_en <= 1'b1;
      r.disc   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_reg_rdata    = r.rdata;
  assign o_reg_rvalid   = r.rvalid;
  assign o_ow_search    = r.srch;
  assign o_ow_read      = r.rd;
  assign o_ow_rom       = r.rom;
  assign o_ow_take      = r.take;
  assign o_ow_delay     = {r.lockdly[15:1], 1'b0};
  assign o_supply_en    = r.sup_en;
  assign o_module_reset = r.mrst;

  // ============================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  AST_OW_OFF: assert property ((o_ow_read || o_ow_search) |->
    $past(r.ival) != 16'h0) else $error("1-wire active at zero interval");
  AST_LOCK: assert property (o_ow_search |->
    !$past(lock)) else $error("discovery while locked");
  AST_FAIL: assert property (r.st == sup_pkg::ST_RD_WR && !r.okf |->
    r.tval == `T_FAIL) else $error("failed read not 4096");
  AST_SCALE: assert property (r.st == sup_pkg::ST_RD_BUS && i_ow_done
    && i_ow_ok |=> r.tval == {{4{$past(i_ow_temp[11])}}, $past(i_ow_temp)})
    else $error("temperature scaling wrong");
  AST_ORDER: assert property (r.st == sup_pkg::ST_INS_CMP && !id_hit &&
    id_rdata > r.nid |=> r.st == sup_pkg::ST_INS_RD &&
    r.idx == 5'($past(r.idx) - 5'h1)) else $error("insertion order wrong");
  AST_FEED: assert property (i_reg_wr && i_reg_addr == `A_CMD &&
    i_reg_wdata == `CMD_CUT && r.cut_len != 16'h0 |=> !o_supply_en)
    else $error("forced cut missing");
  AST_CUTLEN: assert property ($fell(o_supply_en) |->
    r.cut_left == $past(r.cut_len)) else $error("cut length wrong");
  AST_CUTOFF: assert property (r.cut_to == 16'h0 &&
    $past(r.cut_to) == 16'h0 |-> r.cut_idle == 16'h0)
    else $error("cut timer runs while disabled");
  AST_FRAME: assert property (i_frame_valid |=> r.cut_idle == 16'h0 &&
    r.rst_idle == 16'h0) else $error("frame did not restart timers");
  AST_MRST: assert property (o_module_reset |->
    $past(r.rst_to) != 16'h0 ##1 !o_module_reset)
    else $error("module reset without timeout");
  AST_FLIP: assert property (r.st == sup_pkg::ST_RD_WR && !t_hit &&
    r.slot == `LAST_SLOT |=> r.flip != $past(r.flip))
    else $error("status bit did not toggle");
  AST_GAP: assert property (r.st == sup_pkg::ST_IDLE ##1
    r.st == sup_pkg::ST_RD_ID |-> !$past(i_query_active))
    else $error("read started during a query");
  AST_IDWR: assert property (i_reg_wr && id_hit |-> id_we != 4'h0)
    else $error("identifier write dropped");

  COV_SRCH: cover property (o_ow_search ##[1:200] o_ow_take);
  COV_FAIL: cover property (r.st == sup_pkg::ST_RD_WR && !r.okf);
  COV_CUT:  cover property ($fell(o_supply_en));
  COV_MRST: cover property (o_module_reset);
endmodule

// *** src/supervisor_cfg.svh ***
/*
  Constants of the 1-wire manager and communication watchdog: register
  addresses, command codes, special values and timing.
  Assumes it is included by bare name from the package and the top module.
*/
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// ============================================================
// Register addresses
`define A_STATUS   16'h0074
`define A_CUT_TO   16'h0114
`define A_CUT_LEN  16'h0115
`define A_RST_TO   16'h0116
`define A_IVAL     16'h0117
`define A_T1       16'h0258
`define A_ID1      16'h028a
`define A_LOCK     16'h02bb
`define A_T2       16'h02bc
`define A_ID2      16'h02ee
`define A_CMD      16'h03e7
// ============================================================
// Layout and values
`define GRP        5'h09
`define GRP_T      16'h0009
`define GRP_W      16'h0024
`define NSLOT      18
`define LAST_SLOT  5'h11
`define CMD_DISC   16'hdc1a
`define CMD_CUT    16'hfeed
`define T_FAIL     16'h1000
`define IVAL_RST   16'h0001
`define FLIP_BIT   15
`define LOCK_BIT   0
// ============================================================
// Timing
`define SEC_NS     1000000000
`define CLK_NS     40
`endif

// *** src/sup_pkg.sv ***
/*
  Types of the 1-wire manager and communication watchdog.
  Assumes the constants header is on the include path.
*/
`include "supervisor_cfg.svh"
package sup_pkg;
  typedef enum logic [8:0] {
    ST_CLR     = 9'h001,
    ST_IDLE    = 9'h002,
    ST_SRCH    = 9'h004,
    ST_INS_RD  = 9'h008,
    ST_INS_CMP = 9'h010,
    ST_RD_ID   = 9'h020,
    ST_RD_WAIT = 9'h040,
    ST_RD_BUS  = 9'h080,
    ST_RD_WR   = 9'h100
  } state_e;
  typedef enum logic [2:0] {
    SRC_REG = 3'h1, SRC_ID = 3'h2, SRC_TMP = 3'h4
  } src_e;
  typedef struct packed {
    state_e      st;
    logic [4:0]  idx, cnt, slot;
    logic [63:0] nid, rom;
    logic        okf, flip, gap, disc, csr, p_vld, rvalid;
    logic [15:0] tval, cut_to, cut_len, rst_to, ival, lockdly;
    logic [31:0] sec;
    logic [15:0] cut_idle, cut_left, rst_idle, ival_left;
    src_e        p_src;
    logic [1:0]  p_lane;
    logic [15:0] p_data, rdata;
    logic        s1, s2, sup_en, mrst, srch, rd, take;
  } sup_s;
endpackage

// *** src/sensor_mem.sv ***
/*
  Small lane-writable memory for sensor identifiers and temperatures.
  Read data come out of a register one clock after the address.
  Assumes a single clock; contents are not reset and are cleared by the user.
*/
`timescale 1ns/1ps
module sensor_mem #(
  parameter int LANES  = 4,
  parameter int LANE_W = 16,
  parameter int DEPTH  = 18,
  parameter int AW     = 5
) (
  input  wire logic                    i_ref_clk,
  input  wire logic [AW-1:0]           i_addr,
  input  wire logic [LANES-1:0]        i_we,
  input  wire logic [LANES*LANE_W-1:0] i_wdata,
  output logic      [LANES*LANE_W-1:0] o_rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][LANES*LANE_W-1:0] mem;
    logic [LANES*LANE_W-1:0]            rdata;
  } mem_s;
  mem_s r, n;

  always_comb begin
    n = r;
    if (int'(i_addr) < DEPTH) begin
      n.rdata = r.mem[i_addr];
      for (int l = 0; l < LANES; l++) begin
        if (i_we[l]) begin
          n.mem[i_addr][l*LANE_W +: LANE_W] = i_wdata[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    r <= n;
  end

  assign o_rdata = r.rdata;
endmodule

// *** bench/ow_engine_model.sv ***
/*
  Behavioural 1-wire engine: offers its sensor IDs on a search and
  answers temperature reads by ROM code.
  Assumes the supervisor's engine ports, all on one clock.
*/
`timescale 1ns/1ps
module ow_engine_model (
  input  wire logic         i_clk,
  input  wire logic         i_search,
  input  wire logic         i_read,
  input  wire logic [63:0]  i_rom,
  input  wire logic         i_take,
  input  wire logic [255:0] i_ids,
  input  wire logic [47:0]  i_temps,
  input  wire logic [3:0]   i_ok,
  output logic              o_found,
  output logic [63:0]       o_found_id,
  output logic              o_done,
  output logic              o_ok,
  output logic [11:0]       o_temp
);
  int k;
  int n;
  initial begin
    {o_found, o_done, o_ok} = 3'h0;
    o_found_id = 64'h0;
    o_temp = 12'h0;
  end
  // ============================================================
  // Engine
  // IDs are offered highest slot first, so the block has to sort.
  always begin
    @(posedge i_clk);
    if (i_search) begin
      for (k = 3; k >= 0; k--) begin
        @(posedge i_clk);
        #1 o_found_id = i_ids[k*64 +: 64];
        o_found = 1'b1;
        n = 0;
        do begin
          @(posedge i_clk);
          n++;
        end while (!i_take && n < 50);
        #1 o_found = 1'b0;
        o_found_id = ~o_found_id;
      end
      @(posedge i_clk);
      #1 o_done = 1'b1;
      @(posedge i_clk);
      #1 o_done = 1'b0;
    end else if (i_read) begin
      repeat (3) @(posedge i_clk);
      #1 o_done = 1'b1;
      o_ok = 1'b0;
      o_temp = 12'h0;
      for (k = 0; k < 4; k++) begin
        if (i_ids[k*64 +: 64] == i_rom) begin
          o_ok = i_ok[k];
          o_temp = i_temps[k*12 +: 12];
        end
      end
      @(posedge i_clk);
      #1 o_done = 1'b0;
      o_ok = ~o_ok;
      o_temp = ~o_temp;
    end
  end
endmodule

// *** bench/testbench.sv ***
/*
  Self-checking bench of the 1-wire manager and watchdogs.
  Assumes SEC_CYCLES shortened to 20 and the engine model beside it.
*/
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module testbench;
  localparam int SC = 20;
  logic i_ref_clk, i_rst_n, reg_wr, reg_rd, frame_valid, qa;
  logic [15:0] reg_addr, reg_wdata, o_reg_rdata, o_ow_delay;
  logic o_reg_rvalid, o_ow_search, o_ow_read, o_ow_take;
  logic o_supply_en, o_module_reset, fnd, dn, ok;
  logic [63:0] o_ow_rom, fid, ids [4], srt [4], t;
  logic [255:0] idv;
  logic [47:0] tv;
  logic [11:0] tmp;
  int fail_count, num_checks, n_srch, n_rd, n_low, s0, n, i, j;

  onewire_supervisor #(.SEC_CYCLES(SC)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_frame_valid(frame_valid), .i_query_active(qa),
    .i_supply_ok(1'b1), .o_ow_search(o_ow_search), .o_ow_read(o_ow_read),
    .o_ow_rom(o_ow_rom), .o_ow_take(o_ow_take), .o_ow_delay(o_ow_delay),
    .i_ow_found(fnd), .i_ow_found_id(fid), .i_ow_done(dn), .i_ow_ok(ok),
    .i_ow_temp(tmp), .o_supply_en(o_supply_en),
    .o_module_reset(o_module_reset));
  ow_engine_model eng_u (
    .i_clk(i_ref_clk), .i_search(o_ow_search), .i_read(o_ow_read),
    .i_rom(o_ow_rom), .i_take(o_ow_take), .i_ids(idv), .i_temps(tv),
    .i_ok(4'b0111), .o_found(fnd), .o_found_id(fid), .o_done(dn),
    .o_ok(ok), .o_temp(tmp));

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    n_srch += int'(o_ow_search === 1'b1);
    n_rd += int'(o_ow_read === 1'b1);
    n_low += int'(o_supply_en === 1'b0);
  end
  // ============================================================
  // Tasks
  task automatic results();
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    cyc(1);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [15:0] e);
    cyc(1);
    {reg_rd, reg_addr} = {1'b1, a};
    cyc(1);
    reg_rd = 1'b0;
    for (int k = 0; k < 4 && o_reg_rvalid !== 1'b1; k++) cyc(1);
    check(o_reg_rdata, e);
  endtask
  task automatic frame();
    cyc(1);
    frame_valid = 1'b1;
    cyc(1);
    frame_valid = 1'b0;
  endtask
  // Measures how long the controller supply stays off.
  task automatic cut_len(output int m);
    for (m = 0; m < 100 && o_supply_en === 1'b0; m++) cyc(1);
  endtask
  // Failing or unknown sensors read as the fault value.
  function automatic logic [15:0] texp(input logic [63:0] id);
    texp = `T_FAIL;
    for (int k = 0; k < 3; k++)
      if (ids[k] == id) texp = {{4{tv[k*12+11]}}, tv[k*12 +: 12]};
  endfunction
  task automatic chk_slots();
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 4; j++)
        rc(`A_ID1 + 16'(4*i + j), srt[i][63-16*j -: 16]);
      rc(`A_T1 + 16'(i), texp(srt[i]));
    end
    rc(`A_T1 + 16'h4, `T_FAIL);
  endtask
  // ============================================================
  // Sequence
  initial begin
    {reg_wr, reg_rd, frame_valid, i_rst_n, qa} = 5'h0;
    {reg_addr, reg_wdata} = 32'h0;
    void'($urandom(32'hbfed));
    for (i = 0; i < 4; i++) begin
      ids[i] = {$urandom(), $urandom()};
      srt[i] = ids[i];
      idv[i*64 +: 64] = ids[i];
      tv[i*12 +: 12] = 12'($urandom());
    end
    tv[11:0] = 12'h800;
    for (i = 0; i < 4; i++)
      for (j = 0; j < 3; j++)
        if (srt[j] > srt[j+1]) begin
          t = srt[j];
          srt[j] = srt[j+1];
          srt[j+1] = t;
        end
    cyc(20);
    i_rst_n = 1'b1;
    rc(`A_CUT_TO, 16'h0);
    rc(`A_CUT_LEN, 16'h0);
    rc(`A_RST_TO, 16'h0);
    rc(`A_IVAL, `IVAL_RST);
    rc(`A_LOCK, 16'h0);
    cyc(1200);
    chk_slots();
    for (j = 0; j < 4; j++)
      wr(`A_ID2 + 16'(j), srt[2][63-16*j -: 16]);
    cyc(800);
    rc(`A_T2, texp(srt[2]));
    wr(`A_LOCK, 16'h0009);
    cyc(2);
    check(o_ow_delay, 16'h0008);
    s0 = n_srch;
    wr(`A_CMD, `CMD_DISC);
    cyc(100);
    check(n_srch - s0, 0);
    wr(`A_LOCK, 16'h0008);
    wr(`A_CMD, `CMD_DISC);
    cyc(60);
    check(n_srch - s0, 1);
    cyc(1200);
    chk_slots();
    // A read already launched may finish; none may start during a query.
    qa = 1'b1;
    cyc(5);
    s0 = n_rd;
    cyc(200);
    check(n_rd - s0, 0);
    qa = 1'b0;
    wr(`A_IVAL, 16'h0);
    cyc(30);
    s0 = n_rd + n_srch;
    cyc(400);
    check(n_rd + n_srch - s0, 0);
    wr(`A_IVAL, 16'h1);
    wr(`A_CUT_TO, 16'h3);
    wr(`A_CUT_LEN, 16'h2);
    for (i = 0; i < 12; i++) begin
      frame();
      cyc(28);
      check(o_supply_en, 1'b1);
    end
    for (n = 0; n < 100 && o_supply_en === 1'b1; n++) cyc(1);
    // Counting starts 29 cycles after the frame; third tick cuts.
    check(n >= 2*SC - 27 && n <= 3*SC - 28, 1'b1);
    cut_len(n);
    check(n >= 20 && n <= 45, 1'b1);
    wr(`A_CUT_TO, 16'h0);
    s0 = n_low;
    cyc(200);
    check(n_low - s0, 0);
    wr(`A_CMD, `CMD_CUT);
    cyc(1);
    check(o_supply_en, 1'b0);
    cut_len(n);
    check(n >= 20 && n <= 45, 1'b1);
    wr(`A_RST_TO, 16'h2);
    frame();
    for (n = 0; n < 100 && o_module_reset !== 1'b1; n++) cyc(1);
    check(n >= 20 && n <= 65, 1'b1);
    wr(`A_RST_TO, 16'h0);
    results();
  end
  initial begin
    repeat (30000) @(posedge i_ref_clk);
    fail_count++;
    results();
  end
endmodule
